// file: hdl/deser_regs_params.svh
// register offsets, field positions, reset values and counts for the port/eq/clock control group
`ifndef DESER_REGS_PARAMS_SVH
`define DESER_REGS_PARAMS_SVH

`define OFS_PORT_STEERING   8'h34
`define OFS_EQ_CONTROL      8'h35
`define OFS_STRAP_STATUS    8'h37
`define OFS_AUDIO_DIVSEL    8'h3a
`define OFS_EQUALIZER_SETTING_READBACK       8'h3b
`define OFS_ERR_THRESHOLD   8'h41
`define OFS_FAST_BC_CTL     8'h43
`define OFS_EQ_MIN_MAX      8'h45

`define RST_PORT_STEERING   8'h01
`define RST_EQ_CONTROL      8'h00
`define RST_AUDIO_DIVSEL    8'h00
`define RST_ERR_THRESHOLD   8'h03
`define RST_FAST_BC_CTL     8'h00
`define RST_EQ_MIN_MAX      8'h88

`define BIT_SECOND_PORT_SEL 1
`define BIT_FIRST_PORT_SEL  0
`define BIT_EQ_RESTART      6
`define BIT_FLOOR_OVR_EN    5
`define BIT_FLOOR_APPLY     4
`define BIT_MDIV_OVR        7
`define BIT_MSEL_OVR        2
`define BIT_ERR_CNT_EN      4

// writable masks: reserved positions stay zero, except bit 7 of minmax_reg, set by reset until first written
`define MASK_PORT_STEERING  8'h7b
`define MASK_EQ_CONTROL     8'h70
`define MASK_AUDIO_DIVSEL   8'hf7
`define MASK_ERR_THRESHOLD  8'h1f
`define MASK_FAST_BC_CTL    8'h1f
`define MASK_EQ_MIN_MAX     8'h0f

// strap decode settle time before the result is latched
`define STRAP_SETTLE_NS     100
`define CLOCK_PERIOD_NS     4

`endif

// file: hdl/deser_regs_pkg.sv
// types shared by the register group and its error counter
package deser_regs_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] thresh_t;
    typedef logic [5:0] divratio_t;
    typedef enum logic [1:0] {
        STRAP_IDLE   = 2'b00,
        STRAP_SETTLE = 2'b01,
        STRAP_DONE   = 2'b11
    } strap_state_t;
endpackage

// file: hdl/link_error_monitor.sv
// link data-integrity error counter deciding lock loss
`timescale 1ns/1ns
`default_nettype none
module link_error_monitor
    import deser_regs_pkg::*;
#(
    parameter int CW = 4
) (
    input  wire logic              clock,
    input  wire logic              arst_n,
    input  wire logic              count_enable,
    input  wire deser_regs_pkg::thresh_t threshold,
    input  wire logic              err_clock_a,
    input  wire logic              err_clock_b,
    input  wire logic              err_control_data,
    input  wire logic              relock,
    output logic                   lock_lost
);
    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic          lost_reg;
    logic          lost_next;
    logic          any_err;
    logic [1:0]    err_sum;
    logic [CW:0]   count_sum;
    logic          reached;

    // three channels may fail in one cycle; each counts
    assign err_sum   = {1'b0, err_clock_a} + {1'b0, err_clock_b} + {1'b0, err_control_data};
    assign any_err   = |err_sum;
    assign count_sum = {1'b0, count_reg} + {{(CW-1){1'b0}}, err_sum};
    assign reached   = count_sum >= {1'b0, threshold};
    assign lost_next = relock ? 1'b0 :
                       (lost_reg | (any_err & (count_enable ? reached : 1'b1)));
    assign count_next = (relock || !count_enable) ? '0 :
                        (count_sum[CW] ? {CW{1'b1}} : count_sum[CW-1:0]);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= '0;
            lost_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            lost_reg  <= lost_next;
        end
    end

    assign lock_lost = lost_reg;

    chk_disabled_first_err: assert property (@(posedge clock) disable iff (!arst_n)
        (!count_enable && any_err && !relock) |=> lock_lost)
        else $error("lock not dropped on first error with counting off");
    chk_below_thresh_hold: assert property (@(posedge clock) disable iff (!arst_n)
        (count_enable && !lost_reg && !relock && any_err && !reached) |=> !lock_lost)
        else $error("lock dropped below threshold");
    chk_relock_clears: assert property (@(posedge clock) disable iff (!arst_n)
        relock |=> !lock_lost)
        else $error("lock loss not cleared by relock");
    cov_thresh_hit: cover property (@(posedge clock) disable iff (!arst_n)
        count_enable && any_err && reached && !lost_reg);
endmodule
`default_nettype wire

// file: hdl/deser_port_eq_clock_ctl_regs.sv
// port steering, equalizer, strap, audio divider and link error register group
`timescale 1ns/1ns
`default_nettype none
`include "deser_regs_params.svh"

module deser_port_eq_clock_ctl_regs
#(
    parameter int SETTLE_NS = `STRAP_SETTLE_NS
) (
    input  wire logic                      clock,
    input  wire logic                      arst_n,
    input  wire logic                      reg_write,
    input  wire logic                      reg_read,
    input  wire deser_regs_pkg::byte_t     reg_addr,
    input  wire deser_regs_pkg::byte_t     reg_wdata,
    output deser_regs_pkg::byte_t          reg_rdata,
    input  wire logic [2:0]                strap_a_level,
    input  wire logic [2:0]                strap_b_level,
    input  wire logic [5:0]                equalizer_setting_a,
    input  wire logic [5:0]                equalizer_setting_b,
    input  wire logic [1:0]                auto_vco_output_divider_code,
    input  wire logic [1:0]                pll_sm_input_divider,
    input  wire logic                      err_recovered_clock_a,
    input  wire logic                      err_recovered_clock_b,
    input  wire logic                      err_control_data_channel,
    input  wire logic                      relock,
    output logic                           eq_restart_a,
    output logic                           eq_restart_b,
    output logic                           eq_floor_active_a,
    output logic                           eq_floor_active_b,
    output logic [3:0]                     eq_start_value_a,
    output logic [3:0]                     eq_start_value_b,
    output deser_regs_pkg::divratio_t      vco_output_divide,
    output logic [3:0]                     vco_input_divide,
    output logic                           lock_lost
);
    import deser_regs_pkg::*;

    localparam int SETTLE_CYC_I = (SETTLE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS;
    localparam int SETTLE_CYC   = (SETTLE_CYC_I < 1) ? 1 : SETTLE_CYC_I;
    // one extra cycle so the two-flop strap synchroniser holds the pin level at the latch edge
    localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC);

    // per-port copies: index 0 first port, 1 second port
    byte_t        steer_reg;
    byte_t        eqctl_reg   [2];
    byte_t        minmax_reg  [2];
    byte_t        divsel_reg;
    byte_t        thresh_reg;
    byte_t        fastbc_reg;
    byte_t        strap_reg;
    byte_t        rdata_reg;
    byte_t        rdata_next;
    strap_state_t strap_state_reg;
    strap_state_t strap_state_next;
    logic [7:0]   settle_reg;
    logic [2:0]   sa_meta_reg;
    logic [2:0]   sa_sync_reg;
    logic [2:0]   sb_meta_reg;
    logic [2:0]   sb_sync_reg;
    logic         sel_first;
    logic         sel_second;
    logic         rd_second;
    logic         wr_steer;
    logic         wr_divsel;
    logic         wr_thresh;
    logic         wr_fastbc;
    logic [1:0]   port_wr_en;
    logic [2:0]   mdiv_code;
    logic [1:0]   msel_code;
    byte_t        eqs_read;
    logic [5:0]   eqs_a_meta_reg;
    logic [5:0]   eqs_a_reg;
    logic [5:0]   eqs_b_meta_reg;
    logic [5:0]   eqs_b_reg;

    // output divider decode, used for the programmed and automatic paths
    function automatic divratio_t mdiv_ratio(input logic [2:0] code);
        unique case (code)
            3'h0: mdiv_ratio = 6'h20;
            3'h1: mdiv_ratio = 6'h10;
            3'h2: mdiv_ratio = 6'h08;
            3'h3: mdiv_ratio = 6'h04;
            3'h4, 3'h5: mdiv_ratio = 6'h02;
            3'h6, 3'h7: mdiv_ratio = 6'h01;
        endcase
    endfunction

    function automatic logic hit(input byte_t a, input byte_t ofs);
        hit = (a == ofs);
    endfunction

    assign sel_first  = steer_reg[`BIT_FIRST_PORT_SEL];
    assign sel_second = steer_reg[`BIT_SECOND_PORT_SEL];
    assign rd_second  = sel_second;
    assign port_wr_en = {sel_second, sel_first};
    assign wr_steer   = reg_write && hit(reg_addr, `OFS_PORT_STEERING);
    assign wr_divsel  = reg_write && hit(reg_addr, `OFS_AUDIO_DIVSEL);
    assign wr_thresh  = reg_write && hit(reg_addr, `OFS_ERR_THRESHOLD);
    assign wr_fastbc  = reg_write && hit(reg_addr, `OFS_FAST_BC_CTL);

    // shared registers: one copy, written whatever the port selection
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            steer_reg  <= `RST_PORT_STEERING;
            divsel_reg <= `RST_AUDIO_DIVSEL;
            thresh_reg <= `RST_ERR_THRESHOLD;
            fastbc_reg <= `RST_FAST_BC_CTL;
        end else begin
            if (wr_steer)  steer_reg  <= reg_wdata & `MASK_PORT_STEERING;
            if (wr_divsel) divsel_reg <= reg_wdata & `MASK_AUDIO_DIVSEL;
            if (wr_thresh) thresh_reg <= reg_wdata & `MASK_ERR_THRESHOLD;
            if (wr_fastbc) fastbc_reg <= reg_wdata & `MASK_FAST_BC_CTL;
        end
    end

    // per-port registers, written into every selected port
    for (genvar p = 0; p < 2; p++) begin : g_port
        logic wr_eq;
        logic wr_mm;
        logic floor_on;
        assign wr_eq = reg_write && port_wr_en[p] && hit(reg_addr, `OFS_EQ_CONTROL);
        assign wr_mm = reg_write && port_wr_en[p] && hit(reg_addr, `OFS_EQ_MIN_MAX);
        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                eqctl_reg[p]  <= `RST_EQ_CONTROL;
                minmax_reg[p] <= `RST_EQ_MIN_MAX;
            end else begin
                if (wr_eq) eqctl_reg[p]  <= reg_wdata & `MASK_EQ_CONTROL;
                if (wr_mm) minmax_reg[p] <= reg_wdata & `MASK_EQ_MIN_MAX;
            end
        end
        assign floor_on = eqctl_reg[p][`BIT_FLOOR_OVR_EN] & eqctl_reg[p][`BIT_FLOOR_APPLY];
        if (p == 0) begin : g_a
            assign eq_floor_active_a = floor_on;
            assign eq_start_value_a  = floor_on ? minmax_reg[0][3:0] : 4'h0;
        end else begin : g_b
            assign eq_floor_active_b = floor_on;
            assign eq_start_value_b  = floor_on ? minmax_reg[1][3:0] : 4'h0;
        end
    end

    // restart from either copy acts on both ports at once
    assign eq_restart_a = eqctl_reg[0][`BIT_EQ_RESTART] | eqctl_reg[1][`BIT_EQ_RESTART];
    assign eq_restart_b = eq_restart_a;

    // audio clock divider selection
    assign mdiv_code = divsel_reg[`BIT_MDIV_OVR] ? divsel_reg[6:4]
                                                  : {1'b0, auto_vco_output_divider_code};
    assign msel_code = divsel_reg[`BIT_MSEL_OVR] ? divsel_reg[1:0] : pll_sm_input_divider;
    assign vco_input_divide = 4'h1 << msel_code;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            vco_output_divide <= 6'h20;
        end else begin
            vco_output_divide <= mdiv_ratio(mdiv_code);
        end
    end

    // strap pins and equalizer readback come from outside the clock domain
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sa_meta_reg    <= 3'h0;
            sa_sync_reg    <= 3'h0;
            sb_meta_reg    <= 3'h0;
            sb_sync_reg    <= 3'h0;
            eqs_a_meta_reg <= 6'h00;
            eqs_a_reg      <= 6'h00;
            eqs_b_meta_reg <= 6'h00;
            eqs_b_reg      <= 6'h00;
        end else begin
            sa_meta_reg    <= strap_a_level;
            sa_sync_reg    <= sa_meta_reg;
            sb_meta_reg    <= strap_b_level;
            sb_sync_reg    <= sb_meta_reg;
            eqs_a_meta_reg <= equalizer_setting_a;
            eqs_a_reg      <= eqs_a_meta_reg;
            eqs_b_meta_reg <= equalizer_setting_b;
            eqs_b_reg      <= eqs_b_meta_reg;
        end
    end

    // strap decode: wait for settle after reset, then latch once
    always_comb begin
        strap_state_next = strap_state_reg;
        unique case (strap_state_reg)
            STRAP_IDLE:   strap_state_next = STRAP_SETTLE;
            STRAP_SETTLE: if (settle_reg == SETTLE_LAST) strap_state_next = STRAP_DONE;
            STRAP_DONE:   strap_state_next = STRAP_DONE;
            default:      strap_state_next = STRAP_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            strap_state_reg <= STRAP_IDLE;
            settle_reg      <= 8'h00;
            strap_reg       <= 8'h00;
        end else begin
            strap_state_reg <= strap_state_next;
            if (strap_state_reg == STRAP_SETTLE) settle_reg <= settle_reg + 8'h01;
            if (strap_state_reg == STRAP_SETTLE && strap_state_next == STRAP_DONE) begin
                strap_reg <= {1'b1, sb_sync_reg, 1'b1, sa_sync_reg};
            end
        end
    end

    // read mux: second port copies win whenever they are selected
    assign eqs_read = {2'b00, rd_second ? eqs_b_reg : eqs_a_reg};
    always_comb begin
        rdata_next = 8'h00;
        unique case (reg_addr)
            `OFS_PORT_STEERING: rdata_next = steer_reg;
            `OFS_EQ_CONTROL:    rdata_next = eqctl_reg[rd_second];
            `OFS_STRAP_STATUS:  rdata_next = strap_reg;
            `OFS_AUDIO_DIVSEL:  rdata_next = divsel_reg;
            `OFS_EQUALIZER_SETTING_READBACK:     rdata_next = eqs_read;
            `OFS_ERR_THRESHOLD: rdata_next = thresh_reg;
            `OFS_FAST_BC_CTL:   rdata_next = fastbc_reg;
            `OFS_EQ_MIN_MAX:    rdata_next = minmax_reg[rd_second];
            default:            rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= 8'h00;
        end else if (reg_read) begin
            rdata_reg <= rdata_next;
        end
    end
    assign reg_rdata = rdata_reg;

    link_error_monitor #(
        .CW (4)
    ) u_err (
        .clock            (clock),
        .arst_n           (arst_n),
        .count_enable     (thresh_reg[`BIT_ERR_CNT_EN]),
        .threshold        (thresh_reg[3:0]),
        .err_clock_a      (err_recovered_clock_a),
        .err_clock_b      (err_recovered_clock_b),
        .err_control_data (err_control_data_channel),
        .relock           (relock),
        .lock_lost        (lock_lost)
    );

    chk_write_both_ports: assert property (@(posedge clock) disable iff (!arst_n)
        (reg_write && sel_first && sel_second && reg_addr == `OFS_EQ_MIN_MAX)
        |=> minmax_reg[0] == minmax_reg[1])
        else $error("write did not reach both selected ports");
    chk_second_read_wins: assert property (@(posedge clock) disable iff (!arst_n)
        (reg_read && sel_second && reg_addr == `OFS_EQ_MIN_MAX) |=> reg_rdata == $past(minmax_reg[1]))
        else $error("read did not return second port copy");
    chk_floor_gated: assert property (@(posedge clock) disable iff (!arst_n)
        !eqctl_reg[0][`BIT_FLOOR_OVR_EN] |-> (!eq_floor_active_a && eq_start_value_a == 4'h0))
        else $error("floor applied without override");
    chk_restart_both: assert property (@(posedge clock) disable iff (!arst_n)
        (reg_write && reg_addr == `OFS_EQ_CONTROL && reg_wdata[`BIT_EQ_RESTART] && |port_wr_en)
        |=> eq_restart_a && eq_restart_b)
        else $error("restart not applied to both ports");
    chk_strap_done_latch: assert property (@(posedge clock) disable iff (!arst_n)
        $rose(strap_reg[7]) |-> strap_reg[3] && strap_reg[6:4] == $past(sb_sync_reg))
        else $error("strap decode latched wrongly");
    chk_strap_a_latch: assert property (@(posedge clock) disable iff (!arst_n)
        $rose(strap_reg[3]) |-> strap_reg[7] && strap_reg[2:0] == $past(sa_sync_reg))
        else $error("first strap decode latched wrongly");
    chk_reserved_zero: assert property (@(posedge clock) disable iff (!arst_n)
        (steer_reg[7] == 1'b0) && (eqctl_reg[0][3:0] == 4'h0) && (divsel_reg[3] == 1'b0))
        else $error("reserved bit set");
    chk_input_divider: assert property (@(posedge clock) disable iff (!arst_n)
        divsel_reg[`BIT_MSEL_OVR] && divsel_reg[1:0] == 2'b11 |-> vco_input_divide == 4'h8)
        else $error("input divider decode wrong");
    chk_output_divider: assert property (@(posedge clock) disable iff (!arst_n)
        divsel_reg[`BIT_MDIV_OVR] && divsel_reg[6:5] == 2'b11 && !wr_divsel |=> vco_output_divide == 6'h01)
        else $error("output divider decode wrong");
    cov_dual_select: cover property (@(posedge clock) disable iff (!arst_n) sel_first && sel_second && reg_write);
    cov_floor_on: cover property (@(posedge clock) disable iff (!arst_n) eq_floor_active_b);
    cov_strap_done: cover property (@(posedge clock) disable iff (!arst_n) $rose(strap_reg[3]));
endmodule
`default_nettype wire

// file: tb/host_model.sv
// host-side model that issues register writes and reads to the register group
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input  wire logic                  clock,
    output logic                       reg_write,
    output logic                       reg_read,
    output deser_regs_pkg::byte_t      reg_addr,
    output deser_regs_pkg::byte_t      reg_wdata
);
    import deser_regs_pkg::*;

    initial begin
        reg_write = 1'b0;
        reg_read  = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // an idle bus never shows the last address or data
    task automatic release_bus();
        reg_write = 1'b0;
        reg_read  = 1'b0;
        reg_addr  = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask

    task automatic wr(input byte_t a, input byte_t d);
        @(negedge clock);
        reg_write = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clock);
        release_bus();
    endtask

    // one idle cycle after each read keeps read data standing for the checker
    task automatic rd(input byte_t a);
        @(negedge clock);
        reg_read = 1'b1;
        reg_addr = a;
        @(negedge clock);
        release_bus();
        @(negedge clock);
    endtask

    // restart is a write of one followed by a write of zero
    task automatic restart_eq(input byte_t keep);
        wr(8'h35, keep | 8'h40);
        wr(8'h35, keep);
    endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the port, equalizer, strap, divider and link error registers
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, want) begin comparisons++; if ((got) !== (want)) begin error_cnt++; $display("mismatch t=%0t got %h want %h", $time, got, want); end end
module testbench;
    import deser_regs_pkg::*;
    logic        clock, arst_n, reg_write, reg_read, relock, lock_lost;
    byte_t       reg_addr, reg_wdata, reg_rdata, e;
    logic [2:0]  strap_a_level, strap_b_level;
    logic [5:0]  equalizer_setting_a, equalizer_setting_b;
    logic [1:0]  auto_vco_output_divider_code, pll_sm_input_divider;
    logic        err_recovered_clock_a, err_recovered_clock_b, err_control_data_channel;
    logic        eq_restart_a, eq_restart_b, eq_floor_active_a, eq_floor_active_b;
    logic [3:0]  eq_start_value_a, eq_start_value_b, vco_input_divide;
    divratio_t   vco_output_divide;
    int          error_cnt = 0;
    int          comparisons = 0;
    integer      seed = 32'h1bb3;
    byte_t       exp_q[$];
    logic        rd_p1, rd_p2;
    divratio_t   odiv_exp [8] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h02, 6'h01, 6'h01};

    deser_port_eq_clock_ctl_regs #(.SETTLE_NS(4)) deser_port_eq_clock_ctl_regs_i (
        .clock, .arst_n, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata,
        .strap_a_level, .strap_b_level, .equalizer_setting_a, .equalizer_setting_b,
        .auto_vco_output_divider_code, .pll_sm_input_divider, .err_recovered_clock_a,
        .err_recovered_clock_b, .err_control_data_channel, .relock, .eq_restart_a, .eq_restart_b,
        .eq_floor_active_a, .eq_floor_active_b, .eq_start_value_a, .eq_start_value_b,
        .vco_output_divide, .vco_input_divide, .lock_lost);
    host_model host_model_i (.clock, .reg_write, .reg_read, .reg_addr, .reg_wdata);

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // read data is compared with the oldest expectation a cycle and a half after the read is taken
    always @(posedge clock) begin
        rd_p1 <= reg_read;
        rd_p2 <= rd_p1;
    end
    always @(negedge clock) begin
        if (rd_p2 === 1'b1 && exp_q.size() == 0) begin
            error_cnt++;
            $display("mismatch t=%0t read data with no expectation", $time);
        end else if (rd_p2 === 1'b1) begin
            e = exp_q.pop_front();
            `CHECK(reg_rdata, e)
        end
    end

    task automatic rd(input byte_t a, input byte_t x);
        exp_q.push_back(x);
        host_model_i.rd(a);
    endtask

    task automatic wr(input byte_t a, input byte_t d);
        host_model_i.wr(a, d);
        @(negedge clock);
    endtask

    task automatic pulse_err(input logic [2:0] m);
        @(negedge clock);
        {err_recovered_clock_a, err_recovered_clock_b, err_control_data_channel} = m;
        @(negedge clock);
        {err_recovered_clock_a, err_recovered_clock_b, err_control_data_channel} = 3'b000;
        @(negedge clock);
    endtask

    task automatic do_relock();
        @(negedge clock);
        relock = 1'b1;
        @(negedge clock);
        relock = 1'b0;
        @(negedge clock);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #(5000 * 4);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        arst_n = 1'b0;
        relock = 1'b0;
        {err_recovered_clock_a, err_recovered_clock_b, err_control_data_channel} = 3'b000;
        strap_a_level = $random(seed);
        strap_b_level = $random(seed);
        equalizer_setting_a = $random(seed);
        equalizer_setting_b = $random(seed);
        auto_vco_output_divider_code = 2'b10;
        pll_sm_input_divider = 2'b11;
        repeat (5) @(negedge clock);
        arst_n = 1'b1;
        repeat (30) @(negedge clock);
        rd(8'h34, 8'h01);
        rd(8'h35, 8'h00);
        rd(8'h3a, 8'h00);
        rd(8'h41, 8'h03);
        rd(8'h43, 8'h00);
        rd(8'h36, 8'h00);
        rd(8'h37, {1'b1, strap_b_level, 1'b1, strap_a_level});
        wr(8'h37, 8'h00);
        rd(8'h37, {1'b1, strap_b_level, 1'b1, strap_a_level});
        rd(8'h3b, {2'b00, equalizer_setting_a});
        wr(8'h45, 8'h05);
        rd(8'h45, 8'h05);
        wr(8'h34, 8'h02);
        wr(8'h45, 8'h0a);
        rd(8'h45, 8'h0a);
        rd(8'h3b, {2'b00, equalizer_setting_b});
        wr(8'h34, 8'h01);
        rd(8'h45, 8'h05);
        wr(8'h34, 8'h03);
        wr(8'h45, 8'h0c);
        rd(8'h45, 8'h0c);
        rd(8'h3b, {2'b00, equalizer_setting_b});
        wr(8'h34, 8'h01);
        rd(8'h45, 8'h0c);
        wr(8'h35, 8'h10);
        `CHECK({eq_floor_active_a, eq_start_value_a}, 5'h00)
        wr(8'h35, 8'h30);
        `CHECK({eq_floor_active_a, eq_start_value_a, eq_floor_active_b}, 6'h38)
        wr(8'h35, 8'hff);
        rd(8'h35, 8'h70);
        `CHECK({eq_restart_a, eq_restart_b}, 2'b11)
        host_model_i.restart_eq(8'h30);
        @(negedge clock);
        `CHECK({eq_restart_a, eq_restart_b}, 2'b00)
        wr(8'h34, 8'h02);
        wr(8'h35, 8'h30);
        `CHECK({eq_floor_active_b, eq_start_value_b}, 5'h1c)
        for (int i = 0; i < 8; i++) begin
            wr(8'h3a, {1'b1, i[2:0], 4'h0});
            @(negedge clock);
            `CHECK(vco_output_divide, odiv_exp[i])
        end
        wr(8'h3a, 8'h60);
        @(negedge clock);
        `CHECK(vco_output_divide, odiv_exp[{1'b0, auto_vco_output_divider_code}])
        for (int i = 0; i < 4; i++) begin
            wr(8'h3a, {5'h00, 1'b1, i[1:0]});
            `CHECK(vco_input_divide, 4'(1 << i))
        end
        wr(8'h3a, 8'h01);
        `CHECK(vco_input_divide, 4'(1 << pll_sm_input_divider))
        wr(8'h3a, 8'hff);
        rd(8'h3a, 8'hf7);
        wr(8'h43, 8'hff);
        rd(8'h43, 8'h1f);
        pulse_err(3'b001);
        `CHECK(lock_lost, 1'b1)
        do_relock();
        `CHECK(lock_lost, 1'b0)
        wr(8'h41, 8'hf4);
        rd(8'h41, 8'h14);
        pulse_err(3'b100);
        pulse_err(3'b010);
        pulse_err(3'b001);
        `CHECK(lock_lost, 1'b0)
        pulse_err(3'b100);
        `CHECK(lock_lost, 1'b1)
        repeat (4) @(negedge clock);
        `CHECK(exp_q.size(), 0)
        report_and_stop();
    end
endmodule
`default_nettype wire
